// File: verilog/fifo_ctrl_defines.svh
// Offsets, bit positions and reset values of the serial FIFO block
//
// How it works
// - Writing 1 to setup bit 8 empties the transmit buffer; reads 0.
// - Writing 1 to setup bit 7 empties the transmit FIFO; reads 0.
// - Transmit irq at level == threshold, or <= it with select set.
// - Threshold is 0..3 bytes in half duplex, bit 0 only in full duplex.
// - Setup resets while disabled or stop-in-idle; software rewrites it.
// - rx_queue_state bit 7 is a read-only overrun flag, reset 0.
// - Reading the serial data buffer clears the receive overrun flag.
// - rx_queue_state bits 2..0 give the receive level 0 to 4, RO.
// - tx_queue_state bit 7 is a read-only underrun flag, reset 1.
// - Writing the serial data buffer clears the transmit underrun flag.
// - tx_queue_state bits 2..0 give the transmit level 0 to 4, RO.
// - Gate bit 1 turns each receive irq event into a DMA request.
// - Gate bit 0 turns each transmit irq event into a DMA request.
`ifndef FIFO_CTRL_DEFINES_SVH
`define FIFO_CTRL_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFF_DATA_BUF      8'h00
`define OFF_CHAN_CTRL     8'h04
`define OFF_TX_SETUP      8'h08
`define OFF_RX_STATE      8'h0C
`define OFF_TX_STATE      8'h10
`define OFF_DMA_GATE      8'h14
`define OFF_IRQ_STATUS    8'h18
`define OFF_IRQ_MASK      8'h1C

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define TX_BUF_CLR_BIT    8
`define TX_FIFO_CLR_BIT   7
`define TX_CMP_SEL_BIT    6
`define FLAG_BIT          7
`define CTRL_ENABLE_BIT   0
`define CTRL_DUPLEX_BIT   1
`define CTRL_IDLE_BIT     2
`define DMA_RX_BIT        1
`define DMA_TX_BIT        0
`define EVT_TX            0
`define EVT_RX            1
`define EVT_RX_OVR        2
`define EVT_TX_UNR        3

////////////////////////////////////////////////////////////////////////////////
// Sizes and reset values
`define EVT_COUNT         4
`define CAP_HALF          3'h4
`define CAP_FULL          3'h2
`define UNDERRUN_RESET    1'b1
`define OVERRUN_RESET     1'b0

`endif

// File: verilog/fifo_pkg.sv
// Types shared by the serial FIFO block
package fifo_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [2:0] level_type;
    typedef enum logic {
        HALF_DUPLEX = 1'b0,
        FULL_DUPLEX = 1'b1
    } duplex_type;
endpackage

// File: verilog/queue_link_if.sv
// Link between the FIFO control logic and one byte queue
`timescale 1ns/1ps
`default_nettype none
interface queue_link_if;
    logic                push;
    logic                pop;
    logic                clear;
    fifo_pkg::byte_type  wdata;
    fifo_pkg::byte_type  rdata;
    fifo_pkg::level_type level;
    fifo_pkg::level_type cap;
    logic                full;
    logic                empty;

    modport owner (output push, pop, clear, wdata, cap,
                   input rdata, level, full, empty);
    modport store (input push, pop, clear, wdata, cap,
                   output rdata, level, full, empty);
endinterface
`default_nettype wire

// File: verilog/byte_queue.sv
// Byte FIFO with a run-time capacity limit and synchronous clear
`timescale 1ns/1ps
`default_nettype none
module byte_queue #(
    parameter int DEPTH = 4
) (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    queue_link_if.store q
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    fifo_pkg::byte_type  mem_ff [DEPTH];
    logic [PTR_W-1:0]    wr_ptr_ff;
    logic [PTR_W-1:0]    rd_ptr_ff;
    fifo_pkg::level_type count_ff;
    wire logic           do_push;
    wire logic           do_pop;

    // Wrap a pointer at the array end
    function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
        return (int'(p) == DEPTH - 1) ? '0 : PTR_W'(p + 1'b1);
    endfunction

    // Clear beats both push and pop in the same cycle
    assign do_push = q.push && !q.full && !q.clear;
    assign do_pop  = q.pop && !q.empty && !q.clear;
    assign q.full  = (count_ff >= q.cap);
    assign q.empty = (count_ff == 3'h0);
    assign q.rdata = mem_ff[rd_ptr_ff];
    assign q.level = count_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Storage, no reset needed
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff] <= q.wdata;
        end
    end

    // Pointers and fill count
    always_ff @(posedge sys_clk) begin
        if (rst || q.clear) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= 3'h0;
        end else begin
            if (do_push) wr_ptr_ff <= step(wr_ptr_ff);
            if (do_pop) rd_ptr_ff <= step(rd_ptr_ff);
            count_ff <= count_ff + 3'(do_push) - 3'(do_pop);
        end
    end
endmodule // byte_queue
`default_nettype wire

// File: verilog/serial_fifo_control_status.sv
// FIFO control, status, interrupt and DMA request logic of a serial channel
//
// Chosen here: the address map and strobed register access.
`include "fifo_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_fifo_control_status #(
    parameter int DEPTH = 4
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    input  wire logic        idle_mode,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_byte_done,
    input  wire logic        tx_take,
    output logic      [7:0]  tx_data,
    output logic             tx_data_valid,
    output logic             irq,
    output logic             rx_dma_request,
    output logic             tx_dma_request
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    queue_link_if tx_q ();
    queue_link_if rx_q ();

    logic                     cmp_sel_ff;
    logic [1:0]               thr_ff;
    logic                     chan_en_ff;
    fifo_pkg::duplex_type     duplex_ff;
    logic                     stop_idle_ff;
    logic                     dma_rx_en_ff;
    logic                     dma_tx_en_ff;
    logic [`EVT_COUNT-1:0]    status_ff;
    logic [`EVT_COUNT-1:0]    mask_ff;
    logic                     rx_overrun_ff;
    logic                     tx_underrun_ff;
    fifo_pkg::byte_type       tx_buf_ff;
    logic                     tx_buf_valid_ff;
    logic                     tx_hit_ff;
    logic [31:0]              rd_data_ff;
    logic                     irq_ff;
    logic                     rx_dma_ff;
    logic                     tx_dma_ff;
    logic [`EVT_COUNT-1:0]    nxt_status;

    wire logic                wr_buf;
    wire logic                wr_ctrl;
    wire logic                wr_setup;
    wire logic                wr_dma;
    wire logic                wr_stat;
    wire logic                wr_mask;
    wire logic                rd_buf;
    wire logic                tb_clear;
    wire logic                tf_clear;
    wire logic                setup_reset;
    wire logic                load_buf;
    wire fifo_pkg::level_type cap;
    wire fifo_pkg::level_type tx_thr;
    wire logic                tx_hit;
    wire logic                tx_evt;
    wire logic                rx_evt;
    wire logic                rx_ovr_evt;
    wire logic                tx_unr_evt;
    wire logic [`EVT_COUNT-1:0] events;
    wire logic [31:0]         rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Threshold decode per duplex mode
    function automatic fifo_pkg::level_type decode_thr(
        input logic [1:0]           til,
        input fifo_pkg::duplex_type dpx
    );
        return (dpx == fifo_pkg::FULL_DUPLEX) ? {2'h0, til[0]}
                                              : {1'b0, til};
    endfunction

    // Level against threshold, equal or at-or-below
    function automatic logic level_hit(
        input fifo_pkg::level_type lvl,
        input fifo_pkg::level_type thr,
        input logic                sel
    );
        return sel ? (lvl <= thr) : (lvl == thr);
    endfunction

    // Status word: flag in bit 7, level in bits 2..0
    function automatic logic [31:0] state_word(
        input logic                flag,
        input fifo_pkg::level_type lvl
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`FLAG_BIT] = flag;
        w[2:0] = lvl;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign wr_buf   = wr_en && (addr == `OFF_DATA_BUF);
    assign wr_ctrl  = wr_en && (addr == `OFF_CHAN_CTRL);
    assign wr_setup = wr_en && (addr == `OFF_TX_SETUP);
    assign wr_dma   = wr_en && (addr == `OFF_DMA_GATE);
    assign wr_stat  = wr_en && (addr == `OFF_IRQ_STATUS);
    assign wr_mask  = wr_en && (addr == `OFF_IRQ_MASK);
    assign rd_buf   = rd_en && (addr == `OFF_DATA_BUF);

    // Clears act on a written one
    assign tb_clear = wr_setup && wr_data[`TX_BUF_CLR_BIT];
    assign tf_clear = wr_setup && wr_data[`TX_FIFO_CLR_BIT];

    // Stopped channel holds setup at reset
    assign setup_reset = !chan_en_ff || (idle_mode && stop_idle_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Queue hookup; capacity follows the duplex mode
    assign cap = (duplex_ff == fifo_pkg::FULL_DUPLEX) ? `CAP_FULL : `CAP_HALF;

    // Transmit queue fed by data writes; full ones dropped
    assign tx_q.push  = wr_buf;
    assign tx_q.wdata = wr_data[7:0];
    assign tx_q.clear = tf_clear;
    assign tx_q.pop   = load_buf;
    assign tx_q.cap   = cap;

    // Receive queue: shifter in, data reads out
    assign rx_q.push  = rx_byte_done;
    assign rx_q.wdata = rx_byte;
    assign rx_q.clear = !chan_en_ff;
    assign rx_q.pop   = rd_buf;
    assign rx_q.cap   = cap;

    byte_queue #(.DEPTH(DEPTH)) tx_queue (
        .sys_clk (sys_clk),
        .rst     (rst),
        .q       (tx_q.store)
    );

    byte_queue #(.DEPTH(DEPTH)) rx_queue (
        .sys_clk (sys_clk),
        .rst     (rst),
        .q       (rx_q.store)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Events
    // Refill only once empty, so a take never races the load
    assign load_buf = !tx_buf_valid_ff && !tx_q.empty && !tb_clear;

    // Transmit event on a rising threshold match
    assign tx_thr = decode_thr(thr_ff, duplex_ff);
    assign tx_hit = level_hit(tx_q.level, tx_thr, cmp_sel_ff);
    assign tx_evt = tx_hit && !tx_hit_ff;

    // Receive event per stored byte; overflow dropped
    assign rx_evt     = rx_byte_done && !rx_q.full;
    assign rx_ovr_evt = rx_byte_done && rx_q.full;

    // Shifter took the last byte
    assign tx_unr_evt = tx_take && tx_buf_valid_ff && tx_q.empty
                        && !wr_buf;

    assign events = {tx_unr_evt, rx_ovr_evt, rx_evt, tx_evt};

    // Write-one-to-clear, a same-cycle event wins
    assign nxt_status = (status_ff & ~(wr_stat ? wr_data[`EVT_COUNT-1:0]
                                               : {`EVT_COUNT{1'b0}}))
                        | events;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; clear bits read as zero
    assign rd_word =
        (addr == `OFF_DATA_BUF)   ? {24'h00_0000, rx_q.rdata} :
        (addr == `OFF_CHAN_CTRL)  ? {29'h0000_0000, stop_idle_ff,
                                     duplex_ff, chan_en_ff} :
        (addr == `OFF_TX_SETUP)   ? {25'h000_0000, cmp_sel_ff,
                                     4'h0, thr_ff} :
        (addr == `OFF_RX_STATE)   ? state_word(rx_overrun_ff,
                                               rx_q.level) :
        (addr == `OFF_TX_STATE)   ? state_word(tx_underrun_ff,
                                               tx_q.level) :
        (addr == `OFF_DMA_GATE)   ? {30'h0000_0000, dma_rx_en_ff,
                                     dma_tx_en_ff} :
        (addr == `OFF_IRQ_STATUS) ? {28'h000_0000, status_ff} :
        (addr == `OFF_IRQ_MASK)   ? {28'h000_0000, mask_ff} :
                                    32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Channel control and gates
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chan_en_ff   <= 1'b0;
            duplex_ff    <= fifo_pkg::HALF_DUPLEX;
            stop_idle_ff <= 1'b0;
            dma_rx_en_ff <= 1'b0;
            dma_tx_en_ff <= 1'b0;
            mask_ff      <= '0;
        end else begin
            if (wr_ctrl) begin
                chan_en_ff   <= wr_data[`CTRL_ENABLE_BIT];
                duplex_ff    <= fifo_pkg::duplex_type'(
                                    wr_data[`CTRL_DUPLEX_BIT]);
                stop_idle_ff <= wr_data[`CTRL_IDLE_BIT];
            end
            if (wr_dma) begin
                dma_rx_en_ff <= wr_data[`DMA_RX_BIT];
                dma_tx_en_ff <= wr_data[`DMA_TX_BIT];
            end
            if (wr_mask) mask_ff <= wr_data[`EVT_COUNT-1:0];
        end
    end

    // Transmit setup, held at reset while stopped
    always_ff @(posedge sys_clk) begin
        if (rst || setup_reset) begin
            cmp_sel_ff <= 1'b0;
            thr_ff     <= 2'h0;
        end else if (wr_setup) begin
            cmp_sel_ff <= wr_data[`TX_CMP_SEL_BIT];
            thr_ff     <= wr_data[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Holding buffer toward the shifter
    always_ff @(posedge sys_clk) begin
        if (rst || tb_clear) begin
            tx_buf_valid_ff <= 1'b0;
            tx_buf_ff       <= 8'h00;
        end else if (load_buf) begin
            tx_buf_valid_ff <= 1'b1;
            tx_buf_ff       <= tx_q.rdata;
        end else if (tx_take) begin
            tx_buf_valid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags, set beats the access clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_overrun_ff  <= `OVERRUN_RESET;
            tx_underrun_ff <= `UNDERRUN_RESET;
        end else begin
            rx_overrun_ff  <= rx_ovr_evt
                              || (rx_overrun_ff && !rd_buf);
            tx_underrun_ff <= tx_unr_evt
                              || (tx_underrun_ff && !wr_buf);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, DMA pulses and read data
    // Match history starts high: no event out of reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_ff  <= '0;
            tx_hit_ff  <= 1'b1;
            irq_ff     <= 1'b0;
            rx_dma_ff  <= 1'b0;
            tx_dma_ff  <= 1'b0;
            rd_data_ff <= 32'h0000_0000;
        end else begin
            status_ff  <= nxt_status;
            tx_hit_ff  <= tx_hit;
            irq_ff     <= |(nxt_status & mask_ff);
            rx_dma_ff  <= rx_evt && dma_rx_en_ff;
            tx_dma_ff  <= tx_evt && dma_tx_en_ff;
            rd_data_ff <= rd_en ? rd_word : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign rd_data        = rd_data_ff;
    assign tx_data        = tx_buf_ff;
    assign tx_data_valid  = tx_buf_valid_ff;
    assign irq            = irq_ff;
    assign rx_dma_request = rx_dma_ff;
    assign tx_dma_request = tx_dma_ff;
endmodule // serial_fifo_control_status
`default_nettype wire

// File: testbench/shifter_model.sv
// Behavioural serial shifter facing the FIFO block
`timescale 1ns/1ps
`default_nettype none
module shifter_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_data_valid,
    input  wire logic       take_on,
    input  wire logic       rx_go,
    input  wire logic [7:0] rx_val,
    output logic      [7:0] rx_byte = 8'h00,
    output logic            rx_byte_done = 1'b0,
    output logic            tx_take = 1'b0,
    output logic      [7:0] last_taken = 8'h00
);
    ////////////////////////////////////////////////////////////////////////
    // Bytes on command; data toggles between so stale bytes show
    always @(posedge sys_clk) begin
        rx_byte_done <= rx_go && !rst;
        rx_byte      <= rx_go ? rx_val : ~rx_byte;
    end
    ////////////////////////////////////////////////////////////////////////
    // Take offered bytes at most every other cycle
    always @(posedge sys_clk) begin
        tx_take <= !rst && take_on && tx_data_valid && !tx_take;
        if (tx_take && tx_data_valid) begin
            last_taken <= tx_data;
        end
    end
endmodule // shifter_model
`default_nettype wire

// File: testbench/serial_fifo_control_status_props.sv
// Port-level assertions of the serial FIFO block
`include "fifo_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_fifo_control_status_props (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data,
    input wire logic        idle_mode,
    input wire logic [7:0]  rx_byte,
    input wire logic        rx_byte_done,
    input wire logic        tx_take,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_data_valid,
    input wire logic        irq,
    input wire logic        rx_dma_request,
    input wire logic        tx_dma_request
);
    logic [2:0] ctrl_ff;
    logic [1:0] dma_ff;
    logic       wr_setup;
    logic       live;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of control and DMA gate
    assign wr_setup = wr_en && addr == `OFF_TX_SETUP;
    assign live     = ctrl_ff[0] && !(idle_mode && ctrl_ff[2]);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_ff <= 3'h0;
            dma_ff  <= 2'h0;
        end else if (wr_en && addr == `OFF_CHAN_CTRL) begin
            ctrl_ff <= wr_data[2:0];
        end else if (wr_en && addr == `OFF_DMA_GATE) begin
            dma_ff <= wr_data[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Read-back layout and access side effects
    AST_SETUP_CMD_READ0 : assert property (
        $past(rd_en && addr == `OFF_TX_SETUP) |-> rd_data[8:7] == 2'h0)
        else $error("clear bits read set");
    AST_RX_STATE_LAYOUT : assert property (
        $past(rd_en && addr == `OFF_RX_STATE)
        |-> {rd_data[31:8], rd_data[6:3]} == 28'h0 && rd_data[2:0] <= 3'h4)
        else $error("rx state bad");
    AST_TX_STATE_LAYOUT : assert property (
        $past(rd_en && addr == `OFF_TX_STATE)
        |-> {rd_data[31:8], rd_data[6:3]} == 28'h0 && rd_data[2:0] <= 3'h4)
        else $error("tx state bad");
    AST_TX_FIFO_CLEAR : assert property (
        (wr_setup && wr_data[7] && live) ##1 !wr_en
        ##1 (rd_en && addr == `OFF_TX_STATE) |=> rd_data[2:0] == 3'h0)
        else $error("tx level kept");
    AST_UNDERRUN_CLEAR : assert property (
        (wr_en && addr == `OFF_DATA_BUF) ##1 !wr_en
        ##1 (rd_en && addr == `OFF_TX_STATE) |=> !rd_data[7])
        else $error("underrun kept");
    AST_OVERRUN_CLEAR : assert property (
        (rd_en && addr == `OFF_DATA_BUF && !rx_byte_done) ##1 !rx_byte_done
        ##1 (rd_en && addr == `OFF_RX_STATE) |=> !rd_data[7])
        else $error("overrun kept");
    // Buffer cleared on command, else held till taken
    AST_TX_BUF_CLEAR : assert property (
        wr_setup && wr_data[8] && live |=> !tx_data_valid)
        else $error("buffer kept");
    AST_TX_BUF_HOLD : assert property (
        tx_data_valid && !tx_take && !wr_en && !idle_mode
        |=> tx_data_valid && $stable(tx_data))
        else $error("offered byte lost");
    // DMA requests only through an open gate
    AST_RX_DMA_GATED : assert property (
        rx_dma_request |-> $past(rx_byte_done) && dma_ff[1])
        else $error("rx dma ungated");
    AST_TX_DMA_PULSE : assert property (
        tx_dma_request |-> dma_ff[0] ##1 !tx_dma_request)
        else $error("tx dma bad");
    COV_TX_DMA : cover property (tx_dma_request);
    COV_RX_DMA : cover property (rx_dma_request);
    COV_TAKE   : cover property (tx_take && tx_data_valid);
endmodule // serial_fifo_control_status_props
bind serial_fifo_control_status serial_fifo_control_status_props
    u_serial_fifo_control_status_props (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .idle_mode(idle_mode), .rx_byte(rx_byte), .rx_byte_done(rx_byte_done),
    .tx_take(tx_take), .tx_data(tx_data), .tx_data_valid(tx_data_valid),
    .irq(irq), .rx_dma_request(rx_dma_request),
    .tx_dma_request(tx_dma_request)
);
`default_nettype wire

// File: testbench/serial_fifo_control_status_bench.sv
// Self-checking bench of the serial FIFO block
`include "fifo_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_fifo_control_status_bench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0000_0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        idle_mode = 1'b0;
    logic        take_on = 1'b0;
    logic        rx_go = 1'b0;
    logic [7:0]  rx_val = 8'h00;
    logic [31:0] exp_v;
    wire  [31:0] rd_data;
    wire  [7:0]  rx_byte, tx_data, last_taken;
    wire         rx_byte_done, tx_take, tx_data_valid, irq;
    wire         rx_dma_request, tx_dma_request;
    int          errors = 0;
    int          checked = 0;
    int          rx_reqs = 0;
    // Clock and receive DMA tally
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rx_dma_request === 1'b1) rx_reqs++;
    serial_fifo_control_status u_serial_fifo_control_status (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .idle_mode(idle_mode), .rx_byte(rx_byte),
        .rx_byte_done(rx_byte_done), .tx_take(tx_take), .tx_data(tx_data),
        .tx_data_valid(tx_data_valid), .irq(irq),
        .rx_dma_request(rx_dma_request), .tx_dma_request(tx_dma_request));
    shifter_model u_shifter_model (
        .sys_clk(sys_clk), .rst(rst), .tx_data(tx_data),
        .tx_data_valid(tx_data_valid), .take_on(take_on), .rx_go(rx_go),
        .rx_val(rx_val), .rx_byte(rx_byte), .rx_byte_done(rx_byte_done),
        .tx_take(tx_take), .last_taken(last_taken));
    ////////////////////////////////////////////////////////////////////////
    // One-cycle strobes launched after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Read data stand one cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(negedge sys_clk);
        chk($sformatf("register %h", a), exp, rd_data);
    endtask
    task automatic report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far past what the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(`OFF_TX_STATE, 32'h0000_0080);
        rdc(`OFF_RX_STATE, 32'h0000_0000);
        rdc(`OFF_TX_SETUP, 32'h0000_0000);
        rdc(`OFF_DMA_GATE, 32'h0000_0000);
        rdc(8'hFC, 32'h0000_0000);
        $display("reset test done");
        // Enable first, then clear, as software must
        wr(`OFF_CHAN_CTRL, 32'h0000_0001);
        wr(`OFF_TX_SETUP, 32'h0000_01C3);
        rdc(`OFF_TX_SETUP, 32'h0000_0043);
        wr(`OFF_IRQ_MASK, 32'h0000_000F);
        wr(`OFF_DMA_GATE, 32'h0000_0003);
        wr(`OFF_DATA_BUF, 32'h0000_0011);
        repeat (2) @(posedge sys_clk);
        rdc(`OFF_TX_STATE, 32'h0000_0000);
        for (int i = 2; i < 5; i++) wr(`OFF_DATA_BUF, 32'(i * 17));
        rdc(`OFF_TX_STATE, 32'h0000_0003);
        wr(`OFF_TX_SETUP, 32'h0000_0080);
        rdc(`OFF_TX_STATE, 32'h0000_0000);
        chk("buffer", 32'h0000_0111, {23'h0, tx_data_valid, tx_data});
        wr(`OFF_TX_SETUP, 32'h0000_0100);
        @(negedge sys_clk);
        chk("buffer valid", 32'h0, {31'h0, tx_data_valid});
        $display("clear test done");
        // Every threshold code, both duplex modes
        for (int m = 0; m < 8; m++) begin
            wr(`OFF_CHAN_CTRL, {30'h0, m[2], 1'b1});
            wr(`OFF_TX_SETUP, {23'h0, 2'h3, 5'h0, m[1:0]});
            wr(`OFF_IRQ_STATUS, 32'h0000_000F);
            wr(`OFF_DATA_BUF, 32'h0000_005A);
            repeat (4) @(posedge sys_clk);
            exp_v = (m[2] || m[1:0] < 2) ? 32'h1 : 32'h0;
            chk("irq", exp_v, {31'h0, irq});
            rdc(`OFF_IRQ_STATUS, exp_v);
        end
        // At-or-below compare stays matched
        wr(`OFF_CHAN_CTRL, 32'h0000_0001);
        wr(`OFF_TX_SETUP, 32'h0000_01C1);
        wr(`OFF_IRQ_STATUS, 32'h0000_000F);
        wr(`OFF_DATA_BUF, 32'h0000_0066);
        wr(`OFF_DATA_BUF, 32'h0000_0077);
        rdc(`OFF_IRQ_STATUS, 32'h0000_0000);
        wr(`OFF_IRQ_MASK, 32'h0000_0000);
        wr(`OFF_TX_SETUP, 32'h0000_0002);
        wr(`OFF_TX_SETUP, 32'h0000_0080);
        rdc(`OFF_IRQ_STATUS, 32'h0000_0001);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(`OFF_IRQ_MASK, 32'h0000_000F);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        wr(`OFF_IRQ_STATUS, 32'h0000_0001);
        @(negedge sys_clk);
        chk("cleared irq", 32'h0, {31'h0, irq});
        $display("threshold test done");
        // Shifter drains the last byte: underrun
        @(posedge sys_clk);
        take_on <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("taken byte", 32'h66, {24'h0, last_taken});
        rdc(`OFF_TX_STATE, 32'h0000_0080);
        take_on <= 1'b0;
        $display("underrun test done");
        // Five bytes into a four-deep queue
        wr(`OFF_IRQ_STATUS, 32'h0000_000F);
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            rx_go  <= 1'b1;
            rx_val <= 8'hA0 + 8'(i);
        end
        @(posedge sys_clk);
        rx_go <= 1'b0;
        rdc(`OFF_RX_STATE, 32'h0000_0084);
        rdc(`OFF_DATA_BUF, 32'h0000_00A0);
        rdc(`OFF_RX_STATE, 32'h0000_0003);
        chk("rx requests", 32'd4, 32'(rx_reqs));
        rdc(`OFF_IRQ_STATUS, 32'h0000_0006);
        wr(`OFF_DMA_GATE, 32'h0000_0001);
        @(posedge sys_clk);
        rx_go <= 1'b1;
        @(posedge sys_clk);
        rx_go <= 1'b0;
        rdc(`OFF_RX_STATE, 32'h0000_0004);
        chk("rx requests", 32'd4, 32'(rx_reqs));
        $display("receive test done");
        // Setup lost on stop in idle and on disable
        wr(`OFF_TX_SETUP, 32'h0000_0043);
        @(posedge sys_clk);
        idle_mode <= 1'b1;
        rdc(`OFF_TX_SETUP, 32'h0000_0043);
        wr(`OFF_CHAN_CTRL, 32'h0000_0005);
        rdc(`OFF_TX_SETUP, 32'h0000_0000);
        idle_mode <= 1'b0;
        wr(`OFF_CHAN_CTRL, 32'h0000_0000);
        wr(`OFF_TX_SETUP, 32'h0000_0043);
        rdc(`OFF_TX_SETUP, 32'h0000_0000);
        rdc(`OFF_RX_STATE, 32'h0000_0000);
        $display("disable test done");
        report_and_stop();
    end
endmodule // serial_fifo_control_status_bench
`default_nettype wire
